// file: rtl/wdt_sleep_readback.sv
`timescale 1ns/10ps
// Behaviour
// - clear counter on entering sleep
// - keep counting in sleep when enabled
// - clear counter again on leaving sleep
// - hold counter zero while startup timer runs
// - expiry in sleep wakes, no reset
// - expiry in sleep updates timeout/powerdown bits
// - expiry in sleep clears watchdog reset flag
// - expose 18-bit prescale count
// - prescale split low, high, timer bits
// - 5-bit timer value in bits 7..3
// - bit 2 shows armed state
// - views read-only, zero after reset
// - clear without arming is window violation
// - reset flag active low, firmware sets
module wdt_sleep_readback (
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst,
   // register port
   input  wire wdt_sleep_pkg::bus_req_t bus,
   output logic [7:0]                 rdata,
   // core and oscillator pins
   input  wire logic                  sleep_req,
   input  wire logic                  wake_req,
   input  wire logic                  clear_instr,
   input  wire logic                  ost_running,
   // outputs
   output logic                       wake_core,
   output logic                       wdt_reset,
   output logic                       irq
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] sync1_reg, sync2_reg;   // two-stage input sync
   logic [3:0] sync_next;              // raw pin sample
   // gather the four asynchronous pins into one vector
   always_comb begin
      sync_next = {sleep_req, wake_req, clear_instr, ost_running};
   end
   // the startup-timer stage resets high: the timer runs out of reset,
   // so the counter cannot creep for two cycles before the sync catches up
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 4'h1;
         sync2_reg <= 4'h1;
      end else begin
         sync1_reg <= sync_next;
         sync2_reg <= sync1_reg;
      end
   end
   logic s_sleep, s_wake, s_clr, s_ost;
   assign {s_sleep, s_wake, s_clr, s_ost} = sync2_reg;

   // register address decode, used by read and write paths
   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   wdt_sleep_pkg::core_state_t core_reg, core_next;
   logic [wdt_sleep_pkg::PS_W-1:0]  ps_reg, ps_next;    // prescale count
   logic [wdt_sleep_pkg::TMR_W-1:0] tmr_reg, tmr_next;  // timer value
   logic       armed_reg, armed_next;
   logic [7:0] ctrl_reg, ctrl_next;
   logic [1:0] stat_reg, stat_next;
   logic [7:0] rc_reg, rc_next;
   logic [2:0] ev_reg, ev_next;
   logic [2:0] mask_reg, mask_next;
   logic [7:0] rdata_next;
   logic       wake_next, rst_out_next, irq_next;
   logic       clr_any, active, expire, violation, ctrl_wr;
   logic [7:0] view_tmr;

   // timer view: value, armed, top prescale bits
   always_comb begin
      view_tmr = {tmr_reg, armed_reg, ps_reg[17:16]};
   end

   // ----------------------------------------------------------------
   // watchdog counter
   // ----------------------------------------------------------------
   // sleep tracking, counter step, expiry and arming in one pass
   always_comb begin
      ctrl_wr   = bus.wr && hit(bus.addr, wdt_sleep_pkg::OFS_CTRL);
      // asleep counts only with sleep enable set
      active    = ctrl_reg[wdt_sleep_pkg::CTRL_EN_BIT] &&
                  (core_reg != wdt_sleep_pkg::CORE_ASLEEP ||
                   ctrl_reg[wdt_sleep_pkg::CTRL_SLEEP_BIT]);
      expire    = active && (&ps_reg) && (&tmr_reg);
      // sleep state: expiry must be known before the state moves on
      core_next = core_reg;
      case (core_reg)
         wdt_sleep_pkg::CORE_AWAKE:  if (s_sleep) core_next = wdt_sleep_pkg::CORE_ASLEEP;
         wdt_sleep_pkg::CORE_ASLEEP: if (s_wake || expire) core_next = wdt_sleep_pkg::CORE_WAKING;
         wdt_sleep_pkg::CORE_WAKING: core_next = wdt_sleep_pkg::CORE_AWAKE;
         default:                    core_next = wdt_sleep_pkg::CORE_AWAKE;
      endcase
      // windowed mode needs an arming read first
      violation = s_clr && ctrl_reg[wdt_sleep_pkg::CTRL_WIN_BIT] && !armed_reg;
      clr_any   = (core_reg == wdt_sleep_pkg::CORE_AWAKE && s_sleep)
                || core_reg == wdt_sleep_pkg::CORE_WAKING
                || s_ost
                || (s_clr && !violation) || !active || ctrl_wr;
      {tmr_next, ps_next} = {tmr_reg, ps_reg} + 23'h000001;
      if (clr_any || expire) begin
         ps_next  = '0;
         tmr_next = '0;
      end
      // a read of control zero arms; any clear disarms and wins
      armed_next = armed_reg;
      if (bus.rd && hit(bus.addr, wdt_sleep_pkg::OFS_ARM)) armed_next = 1'b1;
      if (clr_any || expire) armed_next = 1'b0;
   end
   // counter registers; reset leaves every view at zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         core_reg  <= wdt_sleep_pkg::CORE_AWAKE;
         ps_reg    <= '0;
         tmr_reg   <= '0;
         armed_reg <= 1'b0;
      end else begin
         core_reg  <= core_next;
         ps_reg    <= ps_next;
         tmr_reg   <= tmr_next;
         armed_reg <= armed_next;
      end
   end

   // ----------------------------------------------------------------
   // status, cause, events and register port
   // ----------------------------------------------------------------
   // firmware writes first, hardware events on top, then the read mux;
   // letting an event override a same-cycle write keeps no event lost
   always_comb begin
      ctrl_next = ctrl_reg;
      if (ctrl_wr) ctrl_next = bus.wdata;
      stat_next = stat_reg;
      rc_next   = rc_reg;
      mask_next = mask_reg;
      if (bus.wr && hit(bus.addr, wdt_sleep_pkg::OFS_RST_CAUSE))
         rc_next = bus.wdata;
      if (bus.wr && hit(bus.addr, wdt_sleep_pkg::OFS_IRQ_MASK))
         mask_next = bus.wdata[2:0];
      if (bus.wr && hit(bus.addr, wdt_sleep_pkg::OFS_CORE_STAT))
         stat_next = bus.wdata[1:0];
      // hardware events win over firmware writes
      if (expire) begin
         stat_next[wdt_sleep_pkg::STAT_TO_BIT] = 1'b0;
         rc_next[wdt_sleep_pkg::RC_WDT_BIT]    = 1'b0;
         if (core_reg == wdt_sleep_pkg::CORE_ASLEEP)
            stat_next[wdt_sleep_pkg::STAT_PD_BIT] = 1'b0;
      end
      if (violation) rc_next[wdt_sleep_pkg::RC_WV_BIT] = 1'b0;
      wake_next    = expire && core_reg == wdt_sleep_pkg::CORE_ASLEEP;
      rst_out_next = (expire && core_reg != wdt_sleep_pkg::CORE_ASLEEP) || violation;
      ev_next = ev_reg;
      if (bus.rd && hit(bus.addr, wdt_sleep_pkg::OFS_IRQ_STAT)) ev_next = '0;
      // set wins over a clear-on-read in the same cycle
      ev_next[wdt_sleep_pkg::EV_WAKE_BIT]  = ev_next[wdt_sleep_pkg::EV_WAKE_BIT] | wake_next;
      ev_next[wdt_sleep_pkg::EV_RESET_BIT] = ev_next[wdt_sleep_pkg::EV_RESET_BIT] | rst_out_next;
      ev_next[wdt_sleep_pkg::EV_WV_BIT]    = ev_next[wdt_sleep_pkg::EV_WV_BIT] | violation;
      irq_next = |(ev_next & mask_next);
      // read path; view registers ignore writes
      rdata_next = wdt_sleep_pkg::READ_UNMAPPED;
      if (bus.rd) begin
         case (bus.addr)
            wdt_sleep_pkg::OFS_PS_LOW:    rdata_next = ps_reg[7:0];
            wdt_sleep_pkg::OFS_PS_HIGH:   rdata_next = ps_reg[15:8];
            wdt_sleep_pkg::OFS_TMR_VIEW:  rdata_next = view_tmr;
            wdt_sleep_pkg::OFS_CTRL:      rdata_next = ctrl_reg;
            wdt_sleep_pkg::OFS_CORE_STAT: rdata_next = {6'h00, stat_reg};
            wdt_sleep_pkg::OFS_RST_CAUSE: rdata_next = rc_reg;
            wdt_sleep_pkg::OFS_IRQ_STAT:  rdata_next = {5'h00, ev_reg};
            wdt_sleep_pkg::OFS_IRQ_MASK:  rdata_next = {5'h00, mask_reg};
            default:                      rdata_next = wdt_sleep_pkg::READ_UNMAPPED;
         endcase
      end
   end
   // register bank and registered outputs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_reg  <= wdt_sleep_pkg::CTRL_RST;
         stat_reg  <= wdt_sleep_pkg::STAT_RST;
         rc_reg    <= wdt_sleep_pkg::RC_RST;
         ev_reg    <= wdt_sleep_pkg::EV_RST;
         mask_reg  <= wdt_sleep_pkg::EV_RST;
         rdata     <= wdt_sleep_pkg::VIEW_RST;
         wake_core <= 1'b0;
         wdt_reset <= 1'b0;
         irq       <= 1'b0;
      end else begin
         ctrl_reg  <= ctrl_next;
         stat_reg  <= stat_next;
         rc_reg    <= rc_next;
         ev_reg    <= ev_next;
         mask_reg  <= mask_next;
         rdata     <= rdata_next;
         wake_core <= wake_next;
         wdt_reset <= rst_out_next;
         irq       <= irq_next;
      end
   end

   // ----------------------------------------------------------------
   // counter checks
   // ----------------------------------------------------------------
   a_sleep_entry_clear: assert property (@(posedge mclk) disable iff (rst)
      (core_reg == wdt_sleep_pkg::CORE_AWAKE && s_sleep) |=> (ps_reg == '0 && tmr_reg == '0))
      else $error("counter not cleared on sleep entry");

   a_sleep_counting: assert property (@(posedge mclk) disable iff (rst)
      (core_reg == wdt_sleep_pkg::CORE_ASLEEP && active && !clr_any && !expire)
      |=> ps_reg == $past(ps_reg) + 18'h00001 || ps_reg == '0)
      else $error("counter stalled in sleep");

   a_disabled_hold: assert property (@(posedge mclk) disable iff (rst)
      (core_reg == wdt_sleep_pkg::CORE_ASLEEP && !ctrl_reg[wdt_sleep_pkg::CTRL_SLEEP_BIT])
      |=> ps_reg == '0 && tmr_reg == '0)
      else $error("counter ran in sleep while disabled");

   a_wake_clear: assert property (@(posedge mclk) disable iff (rst)
      core_reg == wdt_sleep_pkg::CORE_WAKING |=> ps_reg == '0)
      else $error("counter not cleared on wake");

   a_ost_hold: assert property (@(posedge mclk) disable iff (rst)
      s_ost |=> ps_reg == '0 && tmr_reg == '0)
      else $error("counter moved while startup timer runs");

   a_count_step: assert property (@(posedge mclk) disable iff (rst)
      (active && !clr_any && !expire)
      |=> {tmr_reg, ps_reg} == $past({tmr_reg, ps_reg}) + 23'h000001)
      else $error("counter did not step by one");

   a_sleep_no_reset: assert property (@(posedge mclk) disable iff (rst)
      (expire && core_reg == wdt_sleep_pkg::CORE_ASLEEP && !violation)
      |=> wake_core && !wdt_reset)
      else $error("sleep expiry did not wake");

   a_wake_source: assert property (@(posedge mclk) disable iff (rst)
      wake_core |-> core_reg == wdt_sleep_pkg::CORE_WAKING)
      else $error("wake pulse without leaving sleep");

   a_arm_drop: assert property (@(posedge mclk) disable iff (rst)
      clr_any |=> !armed_reg)
      else $error("armed state survived clear");

   a_arm_set: assert property (@(posedge mclk) disable iff (rst)
      (bus.rd && bus.addr == wdt_sleep_pkg::OFS_ARM && !clr_any && !expire) |=> armed_reg)
      else $error("arming read did not arm");

   // ----------------------------------------------------------------
   // register view checks
   // ----------------------------------------------------------------
   a_view_read: assert property (@(posedge mclk) disable iff (rst)
      (bus.rd && bus.addr == wdt_sleep_pkg::OFS_TMR_VIEW)
      |=> rdata == {$past(tmr_reg), $past(armed_reg), $past(ps_reg[17:16])})
      else $error("timer view mismatch");

   a_low_byte: assert property (@(posedge mclk) disable iff (rst)
      (bus.rd && bus.addr == wdt_sleep_pkg::OFS_PS_LOW) |=> rdata == $past(ps_reg[7:0]))
      else $error("prescale low byte mismatch");

   a_high_byte: assert property (@(posedge mclk) disable iff (rst)
      (bus.rd && bus.addr == wdt_sleep_pkg::OFS_PS_HIGH) |=> rdata == $past(ps_reg[15:8]))
      else $error("prescale high byte mismatch");

   a_read_idle: assert property (@(posedge mclk) disable iff (rst)
      !bus.rd |=> rdata == wdt_sleep_pkg::READ_UNMAPPED)
      else $error("read data outside its cycle");

   // ----------------------------------------------------------------
   // status and event checks
   // ----------------------------------------------------------------
   a_status_update: assert property (@(posedge mclk) disable iff (rst)
      (expire && core_reg == wdt_sleep_pkg::CORE_ASLEEP) |=> stat_reg == 2'h0)
      else $error("status bits not updated");

   a_cause_flag: assert property (@(posedge mclk) disable iff (rst)
      expire |=> !rc_reg[wdt_sleep_pkg::RC_WDT_BIT])
      else $error("reset flag not cleared");

   a_cause_write: assert property (@(posedge mclk) disable iff (rst)
      (bus.wr && bus.addr == wdt_sleep_pkg::OFS_RST_CAUSE && !expire)
      |=> rc_reg[wdt_sleep_pkg::RC_WDT_BIT] == $past(bus.wdata[wdt_sleep_pkg::RC_WDT_BIT]))
      else $error("firmware write to reset flag lost");

   a_flag_hold: assert property (@(posedge mclk) disable iff (rst)
      (!expire && !(bus.wr && bus.addr == wdt_sleep_pkg::OFS_RST_CAUSE))
      |=> rc_reg[wdt_sleep_pkg::RC_WDT_BIT] == $past(rc_reg[wdt_sleep_pkg::RC_WDT_BIT]))
      else $error("reset flag moved without cause");

   a_violation_reset: assert property (@(posedge mclk) disable iff (rst)
      violation |=> wdt_reset && !rc_reg[wdt_sleep_pkg::RC_WV_BIT])
      else $error("violation not reported");

   a_event_sticky: assert property (@(posedge mclk) disable iff (rst)
      (ev_reg[wdt_sleep_pkg::EV_WV_BIT] && !(bus.rd && bus.addr == wdt_sleep_pkg::OFS_IRQ_STAT))
      |=> ev_reg[wdt_sleep_pkg::EV_WV_BIT])
      else $error("violation event lost before read");

endmodule : wdt_sleep_readback

// file: rtl/wdt_sleep_pkg.sv
package wdt_sleep_pkg;

   // ----------------------------------------------------------------
   // register map (offsets chosen for the plain register port)
   // ----------------------------------------------------------------
   localparam logic [3:0] OFS_PS_LOW    = 4'h0;  // prescale_count_low
   localparam logic [3:0] OFS_PS_HIGH   = 4'h1;  // prescale_count_high
   localparam logic [3:0] OFS_TMR_VIEW  = 4'h2;  // timer_value_view
   localparam logic [3:0] OFS_CTRL      = 4'h3;  // enable, sleep enable, window mode
   localparam logic [3:0] OFS_CORE_STAT = 4'h4;  // timeout / powerdown status bits
   localparam logic [3:0] OFS_RST_CAUSE = 4'h5;  // reset cause register
   localparam logic [3:0] OFS_ARM       = 4'h6;  // control zero: read arms the window
   localparam logic [3:0] OFS_IRQ_STAT  = 4'h7;  // sticky event bits, clear on read
   localparam logic [3:0] OFS_IRQ_MASK  = 4'h8;  // interrupt mask

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_EN_BIT    = 0;  // watchdog on
   localparam int CTRL_SLEEP_BIT = 1;  // keep counting in sleep
   localparam int CTRL_WIN_BIT   = 2;  // windowed mode
   localparam int STAT_TO_BIT    = 1;  // timeout status bit (active low)
   localparam int STAT_PD_BIT    = 0;  // powerdown status bit (active low)
   localparam int RC_WDT_BIT     = 4;  // watchdog reset flag (active low)
   localparam int RC_WV_BIT      = 5;  // window violation flag (active low)
   localparam int EV_WAKE_BIT    = 0;  // expiry woke the core
   localparam int EV_RESET_BIT   = 1;  // expiry or violation reset
   localparam int EV_WV_BIT      = 2;  // window violation

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int         PS_W         = 18;    // prescale counter width
   localparam int         TMR_W        = 5;     // timer value width
   localparam logic [7:0] VIEW_RST     = 8'h00; // counter views after reset
   localparam logic [7:0] CTRL_RST     = 8'h01; // enabled, no counting in sleep, no window
   localparam logic [7:0] RC_RST       = 8'h3c; // flags set: no cause recorded
   localparam logic [1:0] STAT_RST     = 2'h3;  // timeout and powerdown not set
   localparam logic [2:0] EV_RST       = 3'h0;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // register bus carrier
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;

   // core sleep state
   typedef enum logic [1:0] {
      CORE_AWAKE  = 2'b00,
      CORE_ASLEEP = 2'b01,
      CORE_WAKING = 2'b11
   } core_state_t;

endpackage : wdt_sleep_pkg

// file: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
   // ------------------------------------------------------------
   // design pins and bench state
   // ------------------------------------------------------------
   logic                    mclk;          // 20 MHz clock
   logic                    rst;           // async reset, high
   wdt_sleep_pkg::bus_req_t bus;           // register request
   logic [7:0]              rdata;         // read answer
   logic                    sleep_req;     // core goes to sleep
   logic                    wake_req;      // external wake
   logic                    clear_instr;   // clear instruction
   logic                    ost_running;   // startup timer busy
   logic                    wake_core;     // expiry in sleep
   logic                    wdt_reset;     // expiry or violation
   logic                    irq;           // level interrupt
   int                      bad_count;     // mismatches
   int                      num_checks;    // comparisons made
   logic [7:0]              v;             // read scratch
   logic [7:0]              w;             // second read scratch
   logic [7:0]              k;             // reset pulse count

   wdt_sleep_readback i_wdt_sleep_readback (
      .mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .sleep_req(sleep_req),
      .wake_req(wake_req), .clear_instr(clear_instr), .ost_running(ost_running),
      .wake_core(wake_core), .wdt_reset(wdt_reset), .irq(irq));

   // free-running clock, 50 ns period
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task finish_test;
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test

   // one-cycle write strobe
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask : wr

   // one-cycle read strobe; data stands only in the next cycle
   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd

   // one clear instruction, then count reset pulses over a fixed span
   task clear_and_count(output logic [7:0] n);
      n = 8'h00;
      @(posedge mclk);
      clear_instr <= 1'b1;
      @(posedge mclk);
      clear_instr <= 1'b0;
      repeat (10) begin
         @(posedge mclk);
         #1 if (wdt_reset === 1'b1) n++;
         chk("no wake pulse", {7'h00, wake_core}, 8'h00);
      end
   endtask : clear_and_count

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // startup timer held busy: every view must stay zero
   task t_reset_views;
      repeat (10) @(posedge mclk);
      for (int a = 0; a < 3; a++) begin
         rd(a[3:0], v);
         chk("view after reset", v, wdt_sleep_pkg::VIEW_RST);
         wr(a[3:0], 8'hff);
         rd(a[3:0], v);
         chk("view after write", v, 8'h00);
      end
      rd(4'hf, v);
      chk("unmapped read", v, wdt_sleep_pkg::READ_UNMAPPED);
      rd(wdt_sleep_pkg::OFS_RST_CAUSE, v);
      chk("cause at reset", v, wdt_sleep_pkg::RC_RST);
      @(posedge mclk);
      #1 chk("rdata idle", rdata, wdt_sleep_pkg::READ_UNMAPPED);
      ost_running <= 1'b0;
   endtask : t_reset_views

   // back-to-back reads see the count move by one per cycle
   task t_counting;
      repeat (300) @(posedge mclk);
      wr(wdt_sleep_pkg::OFS_CTRL, 8'h03);
      @(posedge mclk);
      bus <= '{addr: wdt_sleep_pkg::OFS_PS_LOW, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      #1 v = rdata;
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1 w = rdata;
      chk("low byte step", w - v, 8'h01);
      repeat (600) @(posedge mclk);
      rd(wdt_sleep_pkg::OFS_PS_HIGH, v);
      chk("high byte", v, 8'h02);
      rd(wdt_sleep_pkg::OFS_TMR_VIEW, v);
      chk("timer view", v, 8'h00);
   endtask : t_counting

   // arm, sleep, count in sleep, wake
   task t_arm_sleep;
      wr(wdt_sleep_pkg::OFS_CTRL, 8'h07);
      rd(wdt_sleep_pkg::OFS_ARM, v);
      rd(wdt_sleep_pkg::OFS_TMR_VIEW, v);
      chk("armed view", v, 8'h04);
      repeat (300) @(posedge mclk);
      sleep_req <= 1'b1;
      repeat (8) @(posedge mclk);
      rd(wdt_sleep_pkg::OFS_PS_HIGH, v);
      chk("high at sleep", v, 8'h00);
      rd(wdt_sleep_pkg::OFS_TMR_VIEW, v);
      chk("disarmed view", v, 8'h00);
      repeat (600) @(posedge mclk);
      rd(wdt_sleep_pkg::OFS_PS_HIGH, v);
      chk("high in sleep", v, 8'h02);
      sleep_req <= 1'b0;
      wake_req  <= 1'b1;
      @(posedge mclk);
      wake_req  <= 1'b0;
      repeat (8) @(posedge mclk);
      rd(wdt_sleep_pkg::OFS_PS_HIGH, v);
      chk("high at wake", v, 8'h00);
   endtask : t_arm_sleep

   // unarmed clear in window mode; flag, event, mask and re-arm
   task t_window;
      wr(wdt_sleep_pkg::OFS_CTRL, 8'h05);
      wr(wdt_sleep_pkg::OFS_IRQ_MASK, 8'h04);
      clear_and_count(k);
      chk("violation pulses", k, 8'h01);
      chk("irq raised", {7'h00, irq}, 8'h01);
      rd(wdt_sleep_pkg::OFS_RST_CAUSE, v);
      chk("cause flags", v, 8'h1c);
      rd(wdt_sleep_pkg::OFS_IRQ_STAT, v);
      chk("event status", v, 8'h06);
      repeat (2) @(posedge mclk);
      #1 chk("irq cleared", {7'h00, irq}, 8'h00);
      rd(wdt_sleep_pkg::OFS_IRQ_STAT, v);
      chk("status cleared", v, 8'h00);
      wr(wdt_sleep_pkg::OFS_RST_CAUSE, 8'h3c);
      rd(wdt_sleep_pkg::OFS_RST_CAUSE, v);
      chk("cause set back", v, 8'h3c);
      rd(wdt_sleep_pkg::OFS_ARM, v);
      clear_and_count(k);
      chk("armed clear", k, 8'h00);
      wr(wdt_sleep_pkg::OFS_IRQ_MASK, 8'h00);
      clear_and_count(k);
      chk("rearm needed", k, 8'h01);
      chk("irq masked", {7'h00, irq}, 8'h00);
   endtask : t_window

   // sleep with counting in sleep off: counter must stay clear
   task t_sleep_off;
      wr(wdt_sleep_pkg::OFS_CTRL, 8'h01);
      repeat (300) @(posedge mclk);
      sleep_req <= 1'b1;
      repeat (600) @(posedge mclk);
      rd(wdt_sleep_pkg::OFS_PS_HIGH, v);
      chk("high asleep, off", v, 8'h00);
      sleep_req <= 1'b0;
   endtask : t_sleep_off

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      bad_count   = 0;
      num_checks  = 0;
      rst         = 1'b1;
      bus         = '0;
      sleep_req   = 1'b0;
      wake_req    = 1'b0;
      clear_instr = 1'b0;
      ost_running = 1'b1;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      t_reset_views;
      t_counting;
      t_arm_sleep;
      t_window;
      t_sleep_off;
      finish_test;
   end
endmodule : testbench
